/* File: hw/dscc_top.sv */
// Serial command decode, channel registers, calculation timing and power control
// How it works
// - Control bit 0 set grounds every channel output to its signal ground.
// - Power-down keeps all registers; clearing it restores previous outputs.
// - Control bit 1 arms thermal protection; overtemperature forces power-down.
// - Entering thermal shutdown sets readable control bit 4.
// - Thermal shutdown stays latched until control bit 1 is cleared.
// - Each channel has calc A and B; toggle bits pick, eight per write.
// - Calc registers recomputed on input/gain/offset writes; outputs change only by load.
// - Frame is 24 bits: two mode, six address, sixteen data.
// - Frame starts at sync fall; sync rising before bit 24 discards it.
// - Addressed register updates at sync rise; new transfer needs sync low.
// - Readback: special frame names register, contents shift out next transfer.
// - Data-out driven only from read command until its data is shifted.
// - Calculation after a write runs stages of 600, 600 and 300 ns.
// - Non-special modes write data bits 13..0 to addressed channels.
// - Mode 11 input, 10 offset, 01 gain, 00 special function.
// - Input write goes to A when select bit is 0, B when 1.
// - Load during busy is remembered and applied once busy ends.
// - Load refreshes only outputs whose calc register or toggle bit changed since last load.
// - Control bit 2 selects input register B when 1, A when 0.
`timescale 1ns/100ps
module dscc_top (
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic SCLK_IN,
    input wire logic SYNC_N_IN,
    input wire logic SDI_IN,
    input wire logic LOAD_OUTPUTS_N_IN,
    input wire logic OVERTEMP_IN,
    input wire logic [5:0] CHAN_SEL_IN,
    output logic SDO_OUT,
    output logic SDO_OE_OUT,
    output logic CALC_BUSY_OUT,
    output logic OUTPUTS_GROUNDED_OUT,
    output logic THERM_SHUT_OUT,
    output logic [dscc_pkg::DATA_W-1:0] CHAN_DATA_OUT
);
    import dscc_pkg::*;

    typedef struct packed {
        logic pd;
        logic therm_en;
        logic sel_b;
        logic ot;
        logic shut;
        logic [NUM_CHAN-1:0][DATA_W-1:0] in_a;
        logic [NUM_CHAN-1:0][DATA_W-1:0] in_b;
        logic [NUM_CHAN-1:0][DATA_W-1:0] gain;
        logic [NUM_CHAN-1:0][DATA_W-1:0] ofs;
        logic [NUM_CHAN-1:0][DATA_W-1:0] calc_a;
        logic [NUM_CHAN-1:0][DATA_W-1:0] calc_b;
        logic [NUM_CHAN-1:0][DATA_W-1:0] outr;
        logic [NUM_CHAN-1:0] tog;
        logic [NUM_CHAN-1:0] dirty;
        logic [NUM_CHAN-1:0] upd;
        logic load_pend;
        dscc_eng_type eng;
        logic [5:0] ch;
        logic [7:0] cyc;
        logic busy;
        logic rd_arm;
        logic [23:0] rd_word;
        logic grounded;
        logic [DATA_W-1:0] chan_data;
    } dscc_core_type;

    localparam dscc_core_type CORE_RST = '{
        in_a: {NUM_CHAN{INPUT_RST}},
        in_b: {NUM_CHAN{INPUT_RST}},
        gain: {NUM_CHAN{GAIN_RST}},
        ofs: {NUM_CHAN{OFFSET_RST}},
        eng: ST_IDLE,
        default: '0
    };

    dscc_core_type s_reg;
    dscc_core_type s_next;
    logic [2:0] link_s;
    logic [1:0] side_s;
    logic ld_n_s;
    logic hot_s;
    logic frame_valid;
    logic [23:0] frame;
    logic [1:0] f_mode;
    logic [5:0] f_addr;
    logic [15:0] f_data;
    logic [NUM_CHAN-1:0] hit_vec;
    logic [5:0] rd_ch;
    logic [13:0] rd_val;
    logic [5:0] tog_base;

    dscc_sync #(.W(3), .RST_VAL(LINK_IDLE)) u_link_sync (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in({SCLK_IN, SYNC_N_IN, SDI_IN}),
        .q_out(link_s)
    );

    dscc_sync #(.W(2), .RST_VAL(SIDE_IDLE)) u_side_sync (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in({LOAD_OUTPUTS_N_IN, OVERTEMP_IN}),
        .q_out(side_s)
    );

    assign ld_n_s = side_s[1];
    assign hot_s = side_s[0];

    dscc_serial u_serial (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .sclk_in(link_s[2]),
        .sync_n_in(link_s[1]),
        .sdi_in(link_s[0]),
        .rd_arm_in(s_reg.rd_arm),
        .rd_word_in(s_reg.rd_word),
        .frame_valid_out(frame_valid),
        .frame_out(frame),
        .sdo_out(SDO_OUT),
        .sdo_oe_out(SDO_OE_OUT)
    );

    // mode, address, data in that order
    assign f_mode = frame[23:22];
    assign f_addr = frame[21:16];
    assign f_data = frame[15:0];
    assign rd_ch = (f_data[5:0] < 6'(NUM_CHAN)) ? f_data[5:0] : 6'h00;
    assign tog_base = 6'((int'(f_addr) - int'(SF_TOG0)) * 8);

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            hit_vec[i] = chan_hit(f_addr, i);
        end
        case (f_data[RD_KIND_LSB+1:RD_KIND_LSB])
            2'h0: rd_val = s_reg.in_a[rd_ch];
            2'h1: rd_val = s_reg.in_b[rd_ch];
            2'h2: rd_val = s_reg.gain[rd_ch];
            default: rd_val = s_reg.ofs[rd_ch];
        endcase
    end

    always_comb begin
        s_next = s_reg;
        s_next.rd_arm = 1'b0;
        // deferred load refreshes changed channels only
        if (s_reg.load_pend && !s_reg.busy) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (s_reg.upd[i]) begin
                    // toggle bit picks calc A or B
                    s_next.outr[i] = s_reg.tog[i] ? s_reg.calc_b[i] : s_reg.calc_a[i];
                end
            end
            s_next.upd = '0;
            s_next.load_pend = 1'b0;
        end
        // per-channel first stage, then two tail stages
        unique case (s_reg.eng)
            ST_IDLE: begin
                if (|s_reg.dirty) begin
                    s_next.eng = ST_SCAN;
                    s_next.ch = 6'h00;
                    s_next.cyc = 8'(STAGE1_CYC - 1);
                end
            end
            ST_SCAN: begin
                if (!s_reg.dirty[s_reg.ch] || s_reg.cyc == 8'h00) begin
                    if (s_reg.dirty[s_reg.ch]) begin
                        // calc registers are recomputed, never written serially
                        s_next.calc_a[s_reg.ch] = calc_code(s_reg.in_a[s_reg.ch], s_reg.gain[s_reg.ch],
                            s_reg.ofs[s_reg.ch]);
                        s_next.calc_b[s_reg.ch] = calc_code(s_reg.in_b[s_reg.ch], s_reg.gain[s_reg.ch],
                            s_reg.ofs[s_reg.ch]);
                        s_next.dirty[s_reg.ch] = 1'b0;
                        s_next.upd[s_reg.ch] = 1'b1;
                    end
                    s_next.cyc = 8'(STAGE1_CYC - 1);
                    if (s_reg.ch == 6'(NUM_CHAN - 1)) begin
                        s_next.ch = 6'h00;
                        if (!(|s_next.dirty)) begin
                            s_next.eng = ST_TAIL2;
                            s_next.cyc = 8'(STAGE2_CYC - 1);
                        end
                    end else begin
                        s_next.ch = s_reg.ch + 6'h01;
                    end
                end else begin
                    s_next.cyc = s_reg.cyc - 8'h01;
                end
            end
            ST_TAIL2: begin
                if (s_reg.cyc == 8'h00) begin
                    s_next.eng = ST_TAIL3;
                    s_next.cyc = 8'(STAGE3_CYC - 1);
                end else begin
                    s_next.cyc = s_reg.cyc - 8'h01;
                end
            end
            ST_TAIL3: begin
                if (s_reg.cyc == 8'h00) begin
                    s_next.eng = ST_IDLE;
                end else begin
                    s_next.cyc = s_reg.cyc - 8'h01;
                end
            end
        endcase
        // serial writes change registers only on an accepted frame
        if (frame_valid) begin
            unique case (f_mode)
                MODE_INPUT, MODE_OFFSET, MODE_GAIN: begin
                    for (int i = 0; i < NUM_CHAN; i++) begin
                        if (hit_vec[i]) begin
                            s_next.dirty[i] = 1'b1;
                            if (f_mode == MODE_OFFSET) begin
                                s_next.ofs[i] = f_data[DATA_W-1:0];
                            end else if (f_mode == MODE_GAIN) begin
                                s_next.gain[i] = f_data[DATA_W-1:0];
                            end else if (s_reg.sel_b) begin
                                s_next.in_b[i] = f_data[DATA_W-1:0];
                            end else begin
                                s_next.in_a[i] = f_data[DATA_W-1:0];
                            end
                        end
                    end
                end
                MODE_SPECIAL: begin
                    if (f_addr == SF_CTRL) begin
                        s_next.pd = f_data[CTRL_PD_BIT];
                        s_next.therm_en = f_data[CTRL_THERM_BIT];
                        s_next.sel_b = f_data[CTRL_SELB_BIT];
                        // only clearing the arm bit ends shutdown
                        if (!f_data[CTRL_THERM_BIT]) begin
                            s_next.shut = 1'b0;
                            s_next.ot = 1'b0;
                        end
                    end else if (f_addr == SF_READ) begin
                        // arm readback of the named register
                        s_next.rd_arm = 1'b1;
                        if (f_data[RD_CTRL_BIT]) begin
                            s_next.rd_word = {19'h00000, s_reg.ot, 1'b0, s_reg.sel_b, s_reg.therm_en, s_reg.pd};
                        end else begin
                            s_next.rd_word = {10'h000, rd_val};
                        end
                    end else if (f_addr >= SF_TOG0 && f_addr <= SF_TOG4) begin
                        for (int i = 0; i < 8; i++) begin
                            s_next.tog[int'(tog_base) + i] = f_data[i];
                            s_next.upd[int'(tog_base) + i] = 1'b1;
                        end
                        if (s_reg.eng == ST_IDLE) begin
                            s_next.eng = ST_TAIL3;
                            s_next.cyc = 8'(TOGGLE_CYC - 1);
                        end
                    end
                end
            endcase
        end
        if (s_next.therm_en && hot_s) begin
            s_next.shut = 1'b1;
            s_next.ot = 1'b1;
        end
        if (!ld_n_s) begin
            s_next.load_pend = 1'b1;
        end
        s_next.busy = (s_next.eng != ST_IDLE) || (|s_next.dirty);
        s_next.grounded = s_next.pd | s_next.shut;
        if (s_next.grounded || CHAN_SEL_IN >= 6'(NUM_CHAN)) begin
            s_next.chan_data = '0;
        end else begin
            s_next.chan_data = s_reg.outr[CHAN_SEL_IN];
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s_reg <= CORE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign CALC_BUSY_OUT = s_reg.busy;
    assign OUTPUTS_GROUNDED_OUT = s_reg.grounded;
    assign THERM_SHUT_OUT = s_reg.shut;
    assign CHAN_DATA_OUT = s_reg.chan_data;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    sequence seq_tail_entry;
        s_reg.eng == ST_TAIL2 && $past(s_reg.eng) == ST_SCAN;
    endsequence
    sequence seq_load_go;
        s_reg.load_pend && !s_reg.busy;
    endsequence

    chk_pd_ground: assert property (s_reg.pd |-> s_reg.grounded && s_reg.chan_data == '0)
        else $error("power-down did not ground outputs");
    chk_pd_keeps: assert property (s_reg.pd && !s_reg.load_pend |=> $stable(s_reg.outr))
        else $error("power-down changed output registers");
    chk_therm_force: assert property (s_reg.therm_en && hot_s && !frame_valid |=> s_reg.shut && s_reg.grounded)
        else $error("overtemperature did not shut down");
    chk_ot_flag: assert property ($rose(s_reg.shut) |-> s_reg.ot)
        else $error("overtemperature flag not set");
    chk_therm_latch: assert property (s_reg.shut && s_reg.therm_en |=> s_reg.shut || !s_reg.therm_en)
        else $error("thermal shutdown released while armed");
    chk_busy_frozen: assert property (s_reg.busy |=> $stable(s_reg.outr))
        else $error("outputs changed while busy");
    chk_tail_time: assert property (seq_tail_entry |-> ##120 s_reg.eng == ST_TAIL3 ##60 s_reg.eng == ST_IDLE)
        else $error("tail stage timing wrong");
    chk_wr_busy: assert property (frame_valid && f_mode != MODE_SPECIAL && (|hit_vec) |=> s_reg.busy)
        else $error("write did not start calculation");
    chk_load_clear: assert property (seq_load_go ##0 ld_n_s |=> !s_reg.load_pend)
        else $error("pending load not applied after busy");
    chk_upd_only: assert property (seq_load_go ##0 !s_reg.upd[0] |=> $stable(s_reg.outr[0]))
        else $error("unchanged channel refreshed on load");
    chk_ab_route: assert property (frame_valid && f_mode == MODE_INPUT && s_reg.sel_b && hit_vec[0]
        |=> s_reg.in_b[0] == $past(frame[13:0]) && $stable(s_reg.in_a[0]))
        else $error("input write went to wrong register");
endmodule

/* File: include/dscc_pkg.sv */
// Constants, types and helpers for the serial command and channel control block
package dscc_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STAGE1_NS = 600;
    localparam int STAGE2_NS = 600;
    localparam int STAGE3_NS = 300;
    localparam int TOGGLE_BUSY_NS = 600;
    localparam int STAGE1_CYC = (STAGE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAGE2_CYC = (STAGE2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAGE3_CYC = (STAGE3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOGGLE_CYC = (TOGGLE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_CHAN = 40;
    localparam int DATA_W = 14;
    localparam int FRAME_BITS = 24;
    localparam logic [1:0] MODE_SPECIAL = 2'h0;
    localparam logic [1:0] MODE_GAIN = 2'h1;
    localparam logic [1:0] MODE_OFFSET = 2'h2;
    localparam logic [1:0] MODE_INPUT = 2'h3;
    localparam logic [5:0] SF_NOP = 6'h00;
    localparam logic [5:0] SF_CTRL = 6'h01;
    localparam logic [5:0] SF_READ = 6'h05;
    localparam logic [5:0] SF_TOG0 = 6'h0b;
    localparam logic [5:0] SF_TOG4 = 6'h0f;
    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_THERM_BIT = 1;
    localparam int CTRL_SELB_BIT = 2;
    localparam int RD_CTRL_BIT = 12;
    localparam int RD_KIND_LSB = 10;
    localparam logic [13:0] INPUT_RST = 14'h0000;
    localparam logic [13:0] GAIN_RST = 14'h3fff;
    localparam logic [13:0] OFFSET_RST = 14'h2000;
    localparam logic [13:0] MID_CODE = 14'h2000;
    // Synchroniser reset levels: idle high clock and sync, idle high load
    localparam logic [2:0] LINK_IDLE = 3'h6;
    localparam logic [1:0] SIDE_IDLE = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SCAN = 4'b0010,
        ST_TAIL2 = 4'b0100,
        ST_TAIL3 = 4'b1000
    } dscc_eng_type;

    // Group/channel decode of the six address bits
    function automatic logic chan_hit(input logic [5:0] addr, input int ch);
        int grp;
        int idx;
        logic hit;
        grp = ch / 8;
        idx = ch % 8;
        case (addr[5:3])
            3'h0: hit = (addr[2:0] == 3'h0) || (int'(addr[2:0]) == grp + 1);
            3'h6: hit = int'(addr[2:0]) == idx;
            3'h7: hit = (int'(addr[2:0]) == idx) && (grp != 0);
            default: hit = (int'(addr[5:3]) == grp + 1) && (int'(addr[2:0]) == idx);
        endcase
        return hit;
    endfunction

    // Gain and offset correction, clamped to the code range
    function automatic logic [13:0] calc_code(input logic [13:0] x, input logic [13:0] m, input logic [13:0] c);
        logic [28:0] prod;
        logic signed [16:0] sum;
        prod = 29'(x) * 29'({1'b0, m} + 15'h1);
        sum = $signed({3'h0, prod[27:14]}) + $signed({3'h0, c}) - $signed({3'h0, MID_CODE});
        if (sum < 0) begin
            return 14'h0000;
        end
        if (sum > 17'sh03fff) begin
            return 14'h3fff;
        end
        return sum[13:0];
    endfunction
endpackage

/* File: hw/dscc_sync.sv */
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module dscc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } dscc_sync_type;

    dscc_sync_type s_reg;
    dscc_sync_type s_next;

    always_comb begin
        s_next.meta = d_in;
        s_next.stab = s_reg.meta;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= {RST_VAL, RST_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_out = s_reg.stab;
endmodule

/* File: hw/dscc_serial.sv */
// Serial frame receiver and readback shifter, oversampling the link clock
`timescale 1ns/100ps
module dscc_serial (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic sync_n_in,
    input wire logic sdi_in,
    input wire logic rd_arm_in,
    input wire logic [23:0] rd_word_in,
    output logic frame_valid_out,
    output logic [23:0] frame_out,
    output logic sdo_out,
    output logic sdo_oe_out
);
    import dscc_pkg::*;

    typedef struct packed {
        logic sclk_d;
        logic sync_d;
        logic [23:0] sh;
        logic [4:0] cnt;
        logic [23:0] tx;
        logic oe;
        logic live;
        logic fv;
        logic [23:0] frame;
    } dscc_rx_type;

    // Idle link levels so release of reset shows no false edge
    localparam dscc_rx_type RX_RST = '{sclk_d: 1'b1, sync_d: 1'b1, default: '0};

    dscc_rx_type s_reg;
    dscc_rx_type s_next;
    logic sclk_fall;
    logic sclk_rise;
    logic sync_fall;
    logic sync_rise;

    assign sclk_fall = s_reg.sclk_d & ~sclk_in;
    assign sclk_rise = ~s_reg.sclk_d & sclk_in;
    assign sync_fall = s_reg.sync_d & ~sync_n_in;
    assign sync_rise = ~s_reg.sync_d & sync_n_in;

    always_comb begin
        s_next = s_reg;
        s_next.fv = 1'b0;
        s_next.sclk_d = sclk_in;
        s_next.sync_d = sync_n_in;
        if (sync_fall) begin
            s_next.cnt = 5'h00;
            s_next.live = s_reg.oe;
        end
        if (sclk_fall && !sync_n_in) begin
            s_next.sh = {s_reg.sh[22:0], sdi_in};
            if (s_reg.cnt != 5'h1f) begin
                s_next.cnt = s_reg.cnt + 5'h01;
            end
        end
        if (sclk_rise && !sync_n_in && s_reg.live) begin
            s_next.tx = {s_reg.tx[22:0], 1'b0};
        end
        if (sync_rise) begin
            // exact 24-bit frame taken at sync rise
            if (s_reg.cnt == 5'(FRAME_BITS)) begin
                s_next.fv = 1'b1;
                s_next.frame = s_reg.sh;
            end
            // release data-out after the next frame, which shifts the readback out
            if (s_reg.live) begin
                s_next.oe = 1'b0;
                s_next.live = 1'b0;
            end
        end
        if (rd_arm_in) begin
            s_next.oe = 1'b1;
            s_next.tx = rd_word_in;
            s_next.live = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= RX_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign frame_valid_out = s_reg.fv;
    assign frame_out = s_reg.frame;
    assign sdo_out = s_reg.tx[23];
    assign sdo_oe_out = s_reg.oe;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_short_drop: assert property (sync_rise && s_reg.cnt != 5'(FRAME_BITS) |=> !s_reg.fv)
        else $error("short frame accepted");
    chk_msb_first: assert property (sclk_fall && !sync_n_in |=> s_reg.sh[0] == $past(sdi_in))
        else $error("serial bit not shifted in at falling edge");
    chk_oe_release: assert property (sync_rise && s_reg.live && !rd_arm_in |=> !s_reg.oe)
        else $error("data-out still driven after readback");
endmodule

/* File: dv/dscc_host_model.sv */
// Host-side serial master model driving frames and capturing readback
`timescale 1ns/100ps
module dscc_host_model (
    input wire logic clk_in,
    input wire logic sdo_in,
    output logic sclk_out,
    output logic sync_n_out,
    output logic sdi_out
);
    initial begin
        sclk_out = 1'b1;
        sync_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    task automatic half();
        repeat (16) @(posedge clk_in);
    endtask
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
        rd = '0;
        sync_n_out <= 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            sdi_out <= w[23-i];
            half();
            rd = {rd[22:0], sdo_in};
            sclk_out <= 1'b0;
            half();
            sclk_out <= 1'b1;
        end
        half();
        sync_n_out <= 1'b1;
        sdi_out <= ~sdi_out;
        repeat (200) @(posedge clk_in);
    endtask
endmodule

/* File: dv/dscc_top_tb.sv */
// Self-checking bench for the serial command and channel control block
`timescale 1ns/100ps
module dscc_top_tb;
    import dscc_pkg::*;
    logic mclk = 1'b0;
    logic rst, sclk, sync_n, sdi, load_n, hot, sdo, sdo_oe, busy, grounded, shut;
    logic [5:0] chan_sel;
    logic [13:0] chan_data;
    logic [23:0] rd;
    int fail_count = 0;
    int cmp_count = 0;
    always #2.5 mclk = ~mclk;
    dscc_top u_dscc_top (.MCLK_IN(mclk), .SYS_RST_IN(rst), .SCLK_IN(sclk), .SYNC_N_IN(sync_n), .SDI_IN(sdi),
        .LOAD_OUTPUTS_N_IN(load_n), .OVERTEMP_IN(hot), .CHAN_SEL_IN(chan_sel), .SDO_OUT(sdo),
        .SDO_OE_OUT(sdo_oe), .CALC_BUSY_OUT(busy), .OUTPUTS_GROUNDED_OUT(grounded),
        .THERM_SHUT_OUT(shut), .CHAN_DATA_OUT(chan_data));
    // Released data-out reads as the inverse of its last value
    dscc_host_model u_dscc_host_model (.clk_in(mclk), .sdo_in(sdo_oe ? sdo : ~sdo), .sclk_out(sclk), .sync_n_out(sync_n),
        .sdi_out(sdi));
    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic send(input logic [23:0] w);
        u_dscc_host_model.xfer(w, 24, rd);
    endtask
    task automatic ctrl(input logic [15:0] f);
        send({MODE_SPECIAL, SF_CTRL, f});
    endtask
    // Waits out the calculation; running out of time counts as a mismatch
    task automatic idle();
        for (int n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge mclk);
        chk("busy_end", 24'h0, 24'(busy));
        repeat (4) @(posedge mclk);
    endtask
    task automatic load();
        idle();
        load_n <= 1'b0;
        repeat (4) @(posedge mclk);
        load_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    // Read command, then a NOP frame clocks the word out
    task automatic rdback(input logic [15:0] f, input logic [13:0] e);
        send({MODE_SPECIAL, SF_READ, f});
        chk("oe_armed", 24'h1, 24'(sdo_oe));
        send({MODE_SPECIAL, SF_NOP, 16'h0000});
        chk("readback", {10'h0, e}, rd);
        chk("oe_off", 24'h0, 24'(sdo_oe));
    endtask
    initial begin
        rst = 1'b1;
        load_n = 1'b1;
        hot = 1'b0;
        chan_sel = 6'h00;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("data_rst", 24'h0, 24'(chan_data));
        chk("oe_idle", 24'h0, 24'(sdo_oe));
        send({MODE_INPUT, 6'h01, 16'hd234});
        chk("busy", 24'h1, 24'(busy));
        chk("no_load", 24'h0, 24'(chan_data));
        @(posedge mclk) load_n <= 1'b0;
        @(posedge mclk) load_n <= 1'b1;
        idle();
        chk("held_load", 24'h1234, 24'(chan_data));
        u_dscc_host_model.xfer({MODE_INPUT, 6'h01, 16'h3fff}, 20, rd);
        load();
        chk("abort", 24'h1234, 24'(chan_data));
        rdback(16'h0000, 14'h1234);
        for (int k = 0; k < 2; k++) begin
            send({k ? MODE_OFFSET : MODE_GAIN, 6'h02, 16'h0155 + 16'(k)});
            rdback({4'h0, 2'(k + 2), 4'h0, 6'h08}, 14'h0155 + 14'(k));
        end
        ctrl(16'h0004);
        send({MODE_INPUT, 6'h01, 16'h0555});
        load();
        chk("sel_a", 24'h1234, 24'(chan_data));
        rdback(16'h0400, 14'h0555);
        send({MODE_SPECIAL, SF_TOG0, 16'h0001});
        load();
        chk("toggled", 24'h0555, 24'(chan_data));
        ctrl(16'h0005);
        chk("pd_gnd", 24'h1, 24'(grounded));
        chk("pd_data", 24'h0, 24'(chan_data));
        ctrl(16'h0004);
        chk("pu_data", 24'h0555, 24'(chan_data));
        ctrl(16'h0006);
        @(posedge mclk) hot <= 1'b1;
        repeat (10) @(posedge mclk);
        chk("shut", 24'h1, 24'(shut));
        chk("shut_data", 24'h0, 24'(chan_data));
        hot <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("shut_kept", 24'h1, 24'(shut));
        rdback(16'h1000, 14'h0016);
        ctrl(16'h0004);
        chk("shut_off", 24'h0, 24'(shut));
        chk("back_data", 24'h0555, 24'(chan_data));
        close_out();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        close_out();
    end
endmodule
